/* sfr_dev.sv */
// flash side: detects recovery and rescue select-window patterns
//
// Behaviour
// - power loss may leave random startup protocol
// - recovery forces single-line, fetch off until power-up
// - rescue forces single-line, fetch off; persistent config applies at power-up
// - controller rewrites persistent config afterwards
// - controller sends step one before step two
// - chip select high at least 50ns between windows
// - step one windows 7,9,13,17,25,33 ones
// - recovery step two is 8 ones
// - after step two accept single-line commands
// - rescue step two is 16 ones
// - double-edge mode drives ones both edges
// - delivered array reads FFh
// - delivered status reads 00h
// - delivered persistent config reads FFFFh
// - step one sets fetch confirmation, no reset
// - controller then issues reset-enable, reset-memory
`timescale 1ns/100ps
`default_nettype none
module sfr_dev
   import sfr_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // link
   sfr_if.dev LINK,
   // power state and stored configuration
   input wire logic POWER_UP_I,
   input wire logic [1:0] PCFG_PROTO_I,
   input wire logic PCFG_FETCH_I,
   input wire logic BUSY_I,
   // interface state
   output logic [1:0] PROTO_O,
   output logic FETCH_MODE_O,
   output logic FETCH_CONFIRM_O,
   output logic PINNED_O,
   output logic CMD_READY_O,
   output logic PLR_DONE_O,
   output logic IFR_DONE_O,
   output logic ABORT_BUSY_O,
   // delivered values
   output logic [7:0] ARRAY_BYTE_O,
   output logic [7:0] STATUS_O,
   output logic [15:0] PCFG_O
);
   typedef enum logic [2:0] {SFR_IDLE, SFR_STEP1, SFR_STEP2} sfr_st_e;

   function automatic logic [2:0] next_index(input logic [2:0] idx);
      next_index = idx + 3'h1;
   endfunction

   // a clean 7-clock window opens a fresh step one, except while step two is awaited
   function automatic logic opens_step1(input logic ok, input logic [5:0] cnt);
      opens_step1 = ok && (cnt == STEP1_LEN[0]);
   endfunction

   // two-stage synchronisers for every pin
   // reset to all ones: a clock pin already high after release is not taken as a rise
   logic [3:0] s1_r, s2_r, s3_r;
   logic [3:0] pins;
   assign pins = {LINK.sck, LINK.cs_n, LINK.io_line_zero, LINK.io_line_hold_three};
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         s1_r <= 4'hf;
         s2_r <= 4'hf;
         s3_r <= 4'hf;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   logic sck_rise, cs_rise, cs_low, ones;
   assign sck_rise = s2_r[3] & ~s3_r[3];
   assign cs_low = ~s2_r[2];
   assign cs_rise = s2_r[2] & ~s3_r[2];
   assign ones = s2_r[1] & s2_r[0];

   sfr_st_e st_r, st_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic ok_r, ok_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [1:0] proto_r, proto_nxt;
   logic fetch_r, fetch_nxt, conf_r, conf_nxt, pin_r, pin_nxt;
   logic plr_r, plr_nxt, ifr_r, ifr_nxt;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      ok_nxt = ok_r;
      idx_nxt = idx_r;
      proto_nxt = proto_r;
      fetch_nxt = fetch_r;
      conf_nxt = conf_r;
      pin_nxt = pin_r;
      plr_nxt = 1'b0;
      ifr_nxt = 1'b0;
      if (POWER_UP_I) begin
         // stored config may be corrupt; adopt it as-is
         proto_nxt = PCFG_PROTO_I;
         fetch_nxt = PCFG_FETCH_I;
         conf_nxt = ~PCFG_FETCH_I;
         pin_nxt = 1'b0;
         st_nxt = SFR_IDLE;
         idx_nxt = 3'h0;
      end
      if (cs_low && sck_rise) begin
         // count clocks while selected, holding at 63; a clock without all-ones clears ok
         if (cnt_r != 6'h3f) begin
            cnt_nxt = cnt_r + 6'h01;
         end
         if (!ones) begin
            ok_nxt = 1'b0;
         end
      end
      if (cs_rise) begin
         cnt_nxt = 6'h00;
         ok_nxt = 1'b1;
         unique case (st_r)
            SFR_IDLE, SFR_STEP1: begin
               if (ok_r && cnt_r == STEP1_LEN[idx_r]) begin
                  if (idx_r == 3'(NUM_STEP1 - 1)) begin
                     st_nxt = SFR_STEP2;
                     idx_nxt = 3'h0;
                     // fetch ended, array operations untouched
                     conf_nxt = 1'b1;
                     fetch_nxt = 1'b0;
                  end else begin
                     st_nxt = SFR_STEP1;
                     idx_nxt = next_index(idx_r);
                  end
               end else begin
                  // a stray window restarts the search
                  st_nxt = SFR_IDLE;
                  idx_nxt = opens_step1(ok_r, cnt_r) ? 3'h1 : 3'h0;
                  if (opens_step1(ok_r, cnt_r)) begin
                     st_nxt = SFR_STEP1;
                  end
               end
            end
            SFR_STEP2: begin
               // a step two of any other length is dropped; the controller starts over
               st_nxt = SFR_IDLE;
               if (ok_r && cnt_r == PLR_LEN) begin
                  proto_nxt = SFR_PROTO_EXT;
                  fetch_nxt = 1'b0;
                  conf_nxt = 1'b1;
                  pin_nxt = 1'b1;
                  plr_nxt = 1'b1;
               end else if (ok_r && cnt_r == IFR_LEN) begin
                  // only the interface resets; busy work runs on
                  // stored protocol applies again at the next power-up
                  // either sequence ends in single-line mode, fetch off
                  // a pinned state is never undone here
                  proto_nxt = SFR_PROTO_EXT;
                  fetch_nxt = 1'b0;
                  conf_nxt = 1'b1;
                  ifr_nxt = 1'b1;
               end
            end
            default: st_nxt = SFR_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         st_r <= SFR_IDLE;
         cnt_r <= 6'h00;
         ok_r <= 1'b1;
         idx_r <= 3'h0;
         proto_r <= SFR_PROTO_EXT;
         fetch_r <= 1'b0;
         conf_r <= 1'b1;
         pin_r <= 1'b0;
         plr_r <= 1'b0;
         ifr_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         ok_r <= ok_nxt;
         idx_r <= idx_nxt;
         proto_r <= proto_nxt;
         fetch_r <= fetch_nxt;
         conf_r <= conf_nxt;
         pin_r <= pin_nxt;
         plr_r <= plr_nxt;
         ifr_r <= ifr_nxt;
      end
   end

   assign PROTO_O = proto_r;
   assign FETCH_MODE_O = fetch_r;
   assign FETCH_CONFIRM_O = conf_r;
   assign PINNED_O = pin_r;
   assign CMD_READY_O = (proto_r == SFR_PROTO_EXT) && !fetch_r;
   assign PLR_DONE_O = plr_r;
   assign IFR_DONE_O = ifr_r;
   // rescue never aborts internal work
   assign ABORT_BUSY_O = 1'b0 & BUSY_I;
   assign ARRAY_BYTE_O = ARRAY_ERASED;
   assign STATUS_O = STATUS_DELIVERED;
   assign PCFG_O = PCFG_DELIVERED;
endmodule
`default_nettype wire

/* sfr_pkg.sv */
// constants and types shared by both ends of the flash rescue link
package sfr_pkg;
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned DESEL_MIN_NS = 50;
   localparam int unsigned DESEL_MIN_CYC = (DESEL_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned SCK_HALF_CYC = 6;
   localparam int unsigned NUM_STEP1 = 6;
   localparam logic [5:0] STEP1_LEN [NUM_STEP1] = '{6'h07, 6'h09, 6'h0d, 6'h11, 6'h19, 6'h21};
   localparam logic [5:0] PLR_LEN = 6'h08;
   localparam logic [5:0] IFR_LEN = 6'h10;
   localparam logic [7:0] ARRAY_ERASED = 8'hff;
   localparam logic [7:0] STATUS_DELIVERED = 8'h00;
   localparam logic [15:0] PCFG_DELIVERED = 16'hffff;
   typedef enum logic [1:0] {SFR_PROTO_EXT, SFR_PROTO_DUAL, SFR_PROTO_QUAD} sfr_proto_e;
   typedef enum logic [1:0] {SFR_SEQ_NONE, SFR_SEQ_PLR, SFR_SEQ_IFR} sfr_seq_e;
endpackage

/* sfr_if.sv */
// serial link between flash controller and flash rescue detector
`timescale 1ns/100ps
`default_nettype none
interface sfr_if;
   logic sck;
   logic cs_n;
   logic io_line_zero;
   logic io_line_hold_three;
   modport ctrl (output sck, output cs_n, output io_line_zero, output io_line_hold_three);
   modport dev (input sck, input cs_n, input io_line_zero, input io_line_hold_three);
endinterface
`default_nettype wire

/* sfr_ctrl.sv */
// controller side: issues recovery and rescue select-window sequences
`timescale 1ns/100ps
`default_nettype none
module sfr_ctrl
   import sfr_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // link
   sfr_if.ctrl LINK,
   // request
   input wire logic START_I,
   input wire logic RESCUE_I,
   input wire logic DTR_I,
   output logic BUSY_O,
   output logic DONE_O,
   output logic REWRITE_CFG_O,
   output logic SW_RESET_O
);
   typedef enum logic [1:0] {SFC_IDLE, SFC_DESEL, SFC_CLK} sfc_st_e;

   sfc_st_e st_r, st_nxt;
   logic [2:0] win_r, win_nxt;
   logic [5:0] edges_r, edges_nxt, target;
   logic [3:0] tmr_r, tmr_nxt;
   logic sck_r, sck_nxt, cs_r, cs_nxt, resc_r, resc_nxt, done_r, done_nxt;

   // windows 0..5 are step one, window 6 is step two
   always_comb begin
      if (win_r < 3'(NUM_STEP1)) begin
         target = STEP1_LEN[win_r];
      end else begin
         target = resc_r ? IFR_LEN : PLR_LEN;
      end
   end

   always_comb begin
      st_nxt = st_r;
      win_nxt = win_r;
      edges_nxt = edges_r;
      tmr_nxt = tmr_r;
      sck_nxt = sck_r;
      cs_nxt = cs_r;
      resc_nxt = resc_r;
      done_nxt = 1'b0;
      unique case (st_r)
         SFC_IDLE: begin
            if (START_I) begin
               resc_nxt = RESCUE_I;
               win_nxt = 3'h0;
               tmr_nxt = 4'h0;
               st_nxt = SFC_DESEL;
            end
         end
         SFC_DESEL: begin
            // deselect gap at least the minimum time
            tmr_nxt = tmr_r + 4'h1;
            if (tmr_r == 4'(DESEL_MIN_CYC)) begin
               if (win_r == 3'(NUM_STEP1 + 1)) begin
                  st_nxt = SFC_IDLE;
                  done_nxt = 1'b1;
               end else begin
                  cs_nxt = 1'b0;
                  edges_nxt = 6'h00;
                  tmr_nxt = 4'h0;
                  st_nxt = SFC_CLK;
               end
            end
         end
         SFC_CLK: begin
            tmr_nxt = tmr_r + 4'h1;
            if (tmr_r == 4'(SCK_HALF_CYC - 1)) begin
               tmr_nxt = 4'h0;
               if (!sck_r && edges_r == target) begin
                  // select rises before the next clock
                  cs_nxt = 1'b1;
                  win_nxt = win_r + 3'h1;
                  st_nxt = SFC_DESEL;
               end else begin
                  sck_nxt = ~sck_r;
                  if (!sck_r) begin
                     edges_nxt = edges_r + 6'h01;
                  end
               end
            end
         end
         default: st_nxt = SFC_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         st_r <= SFC_IDLE;
         win_r <= 3'h0;
         edges_r <= 6'h00;
         tmr_r <= 4'h0;
         sck_r <= 1'b0;
         cs_r <= 1'b1;
         resc_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         win_r <= win_nxt;
         edges_r <= edges_nxt;
         tmr_r <= tmr_nxt;
         sck_r <= sck_nxt;
         cs_r <= cs_nxt;
         resc_r <= resc_nxt;
         done_r <= done_nxt;
      end
   end

   // ones held throughout; in double-edge mode both edges carry ones
   assign LINK.io_line_zero = 1'b1 | DTR_I;
   assign LINK.io_line_hold_three = 1'b1;
   assign LINK.sck = sck_r;
   assign LINK.cs_n = cs_r;
   assign BUSY_O = (st_r != SFC_IDLE);
   assign DONE_O = done_r;
   // follow-up actions for the host software
   assign REWRITE_CFG_O = done_r;
   assign SW_RESET_O = done_r;
endmodule
`default_nettype wire

/* sfr_asserts.sv */
// assertions on the serial link between controller and detector
`timescale 1ns/100ps
`default_nettype none
module sfr_asserts
   import sfr_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic io_line_zero,
   input wire logic io_line_hold_three
);
   logic [5:0] cnt_r, cnt_nxt, hi_r, hi_nxt, prev_r, prev_nxt, pred;
   logic sck_r, cs_r;
   // counts stay valid on the cs_n rise edge and clear one cycle later
   always_comb begin
      cnt_nxt = cs_n ? 6'h00 : cnt_r + {5'h00, sck & ~sck_r};
      hi_nxt = cs_n ? hi_r + {5'h00, hi_r != 6'h3f} : 6'h00;
      prev_nxt = (cs_n & ~cs_r) ? cnt_r : prev_r;
      case (cnt_r)
         6'h09: pred = 6'h07;
         6'h0d: pred = 6'h09;
         6'h11: pred = 6'h0d;
         6'h19: pred = 6'h11;
         6'h21: pred = 6'h19;
         default: pred = 6'h21;
      endcase
   end
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         cnt_r <= 6'h00;
         hi_r <= 6'h00;
         prev_r <= 6'h00;
         sck_r <= 1'b0;
         cs_r <= 1'b1;
      end else begin
         cnt_r <= cnt_nxt;
         hi_r <= hi_nxt;
         prev_r <= prev_nxt;
         sck_r <= sck;
         cs_r <= cs_n;
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   a_data_ones: assert property (!cs_n |-> io_line_zero && io_line_hold_three)
      else $error("data line low inside a window");
   a_desel_gap: assert property ($fell(cs_n) |-> hi_r >= 6'h0d)
      else $error("deselect gap too short");
   a_sck_still: assert property (cs_n |-> !sck)
      else $error("serial clock high while deselected");
   a_sck_half: assert property ($changed(sck) |=> $stable(sck) [*5])
      else $error("serial clock half period too short");
   a_win_count: assert property ($rose(cs_n) |->
      cnt_r inside {6'h07, 6'h09, 6'h0d, 6'h11, 6'h19, 6'h21, 6'h08, 6'h10})
      else $error("window clock count not allowed");
   a_step_order: assert property ($rose(cs_n) && cnt_r != 6'h07 |-> prev_r == pred)
      else $error("window out of order");
   a_seq_runs: assert property ($rose(cs_n) && cnt_r != 6'h08 && cnt_r != 6'h10 |-> ##[13:60] $fell(cs_n))
      else $error("sequence stalled between windows");
   a_win_bound: assert property ($fell(cs_n) |-> ##[1:420] $rose(cs_n))
      else $error("window never closed");
   c_plr: cover property ($rose(cs_n) && cnt_r == 6'h08);
   c_ifr: cover property ($rose(cs_n) && cnt_r == 6'h10);
   c_long: cover property ($rose(cs_n) && cnt_r == 6'h21);
endmodule
`default_nettype wire

/* serial_flash_interface_rescue_tb_top.sv */
// testbench: controller and detector back to back, a second detector fed by bench traffic
`timescale 1ns/100ps
`default_nettype none
module serial_flash_interface_rescue_tb_top
   import sfr_pkg::*;
;
   logic clk, rst, start, rescue, dtr, pwr_up, pf, op_busy;
   logic [1:0] pp, proto_a;
   logic fetch_a, conf_a, pin_a, rdy_a, plr_a, ifr_a, abort_a, plr_b, ifr_b, busy_o, done_o, rew_o, swr_o;
   logic [7:0] arr_a, st_a;
   logic [15:0] pcfg_a;
   int failures, n_compared, n_plr, n_ifr, n_plr_b, n_ifr_b, n_done;
   int m_proto, m_fetch, m_pin, e_plr, e_ifr, e_done, eb_plr, eb_ifr;
   bit hung;
   int t_full[6] = '{1, 1, 0, 1, 1, 1};
   int t_w6[6] = '{33, 33, 33, 34, 33, 33};
   int t_zp[6] = '{-1, 5, -1, -1, -1, -1};
   int t_last[6] = '{12, 8, 8, 8, 16, 8};
   sfr_if if_a();
   sfr_if if_b();
   sfr_ctrl u_sfr_ctrl (.CLK_I(clk), .SYS_RST_I(rst), .LINK(if_a), .START_I(start), .RESCUE_I(rescue),
      .DTR_I(dtr), .BUSY_O(busy_o), .DONE_O(done_o), .REWRITE_CFG_O(rew_o), .SW_RESET_O(swr_o));
   sfr_dev u_sfr_dev (.CLK_I(clk), .SYS_RST_I(rst), .LINK(if_a), .POWER_UP_I(pwr_up), .PCFG_PROTO_I(pp),
      .PCFG_FETCH_I(pf), .BUSY_I(op_busy), .PROTO_O(proto_a), .FETCH_MODE_O(fetch_a), .FETCH_CONFIRM_O(conf_a),
      .PINNED_O(pin_a), .CMD_READY_O(rdy_a), .PLR_DONE_O(plr_a), .IFR_DONE_O(ifr_a), .ABORT_BUSY_O(abort_a),
      .ARRAY_BYTE_O(arr_a), .STATUS_O(st_a), .PCFG_O(pcfg_a));
   sfr_dev u_sfr_dev_b (.CLK_I(clk), .SYS_RST_I(rst), .LINK(if_b), .POWER_UP_I(pwr_up), .PCFG_PROTO_I(pp),
      .PCFG_FETCH_I(pf), .BUSY_I(op_busy), .PROTO_O(), .FETCH_MODE_O(), .FETCH_CONFIRM_O(), .PINNED_O(),
      .CMD_READY_O(), .PLR_DONE_O(plr_b), .IFR_DONE_O(ifr_b), .ABORT_BUSY_O(), .ARRAY_BYTE_O(), .STATUS_O(),
      .PCFG_O());
   sfr_asserts u_sfr_asserts (.CLK_I(clk), .SYS_RST_I(rst), .sck(if_a.sck), .cs_n(if_a.cs_n),
      .io_line_zero(if_a.io_line_zero), .io_line_hold_three(if_a.io_line_hold_three));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      n_plr += int'(plr_a === 1'b1);
      n_ifr += int'(ifr_a === 1'b1);
      n_plr_b += int'(plr_b === 1'b1);
      n_ifr_b += int'(ifr_b === 1'b1);
      n_done += int'(done_o === 1'b1);
   end
   task automatic cmp_st(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_ev(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic power_up;
      @(posedge clk);
      pp <= 2'($urandom_range(2));
      pf <= 1'($urandom_range(1));
      pwr_up <= 1'b1;
      @(posedge clk);
      pwr_up <= 1'b0;
      #1 m_proto = pp;
      m_fetch = pf;
      m_pin = 0;
      repeat (2) @(posedge clk);
      #1 cmp_st({12'h000, proto_a, fetch_a, rdy_a},
         {12'h000, 2'(m_proto), 1'(m_fetch), 1'(m_proto + m_fetch == 0)});
   endtask
   // stored config inputs change too; no sequence may adopt them
   task automatic run_ctrl(input logic resc);
      int i;
      @(posedge clk);
      start <= 1'b1;
      rescue <= resc;
      dtr <= 1'($urandom_range(1));
      op_busy <= 1'($urandom_range(1));
      pp <= 2'($urandom_range(2));
      pf <= 1'($urandom_range(1));
      @(posedge clk);
      start <= 1'b0;
      #1 cmp_st({15'h0000, busy_o}, 16'h0001);
      repeat (100) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (i = 0; i < 4000 && done_o !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 4000) begin
         failures++;
         hung = 1'b1;
         return;
      end
      cmp_st({14'h0000, rew_o, swr_o}, 16'h0003);
      e_done++;
      // both sequences end in single-line mode with fetch off; only recovery pins it
      m_proto = 0;
      m_fetch = 0;
      if (resc !== 1'b1) begin
         m_pin = 1;
         e_plr++;
      end else begin
         e_ifr++;
      end
      repeat (20) @(posedge clk);
      #1 cmp_st({15'h0000, busy_o}, 16'h0000);
      cmp_ev(n_done, e_done);
   endtask
   // bench link clock, 48ns period; data lines flip to zero between windows
   task automatic send_win(input int n, input int zp);
      @(posedge clk);
      if_b.io_line_zero <= 1'b1;
      if_b.io_line_hold_three <= 1'b1;
      repeat (SCK_HALF_CYC) @(posedge clk);
      if_b.cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         if (i == zp) if_b.io_line_zero <= 1'b0;
         repeat (SCK_HALF_CYC) @(posedge clk);
         if_b.sck <= 1'b1;
         repeat (SCK_HALF_CYC) @(posedge clk);
         if_b.sck <= 1'b0;
      end
      repeat (SCK_HALF_CYC) @(posedge clk);
      if_b.cs_n <= 1'b1;
      repeat (15) @(posedge clk);
      if_b.io_line_zero <= 1'b0;
      if_b.io_line_hold_three <= 1'b0;
   endtask
   task automatic b_seq(input int full, input int w6, input int zp, input int last);
      int q[$];
      if (full != 0) q = '{7, 9, 13, 17, 25, w6};
      q.push_back(last);
      foreach (q[i]) send_win(q[i], (i == 2) ? zp : -1);
   endtask
   initial begin
      rst = 1'b1;
      {start, rescue, dtr, pwr_up, pf, op_busy, pp} = 8'h00;
      {if_b.sck, if_b.cs_n, if_b.io_line_zero, if_b.io_line_hold_three} = 4'h4;
      void'($urandom(13665));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 cmp_st({arr_a, st_a}, 16'hff00);
      cmp_st(pcfg_a, 16'hffff);
      for (int k = 0; k < 4 && !hung; k++) begin
         if (k != 1) power_up();
         run_ctrl(1'(k == 1 || k == 2));
         cmp_st({10'h000, proto_a, fetch_a, conf_a, pin_a, rdy_a},
            {10'h000, 2'(m_proto), 1'(m_fetch), 1'b1, 1'(m_pin), 1'(m_proto + m_fetch == 0)});
         cmp_st({15'h0000, abort_a}, 16'h0000);
         cmp_ev(n_plr, e_plr);
         cmp_ev(n_ifr, e_ifr);
      end
      @(posedge clk);
      for (int k = 0; k < 6 && !hung; k++) begin
         b_seq(t_full[k], t_w6[k], t_zp[k], t_last[k]);
         if (t_full[k] != 0 && t_w6[k] == 33 && t_zp[k] < 0) begin
            eb_plr += int'(t_last[k] == 8);
            eb_ifr += int'(t_last[k] == 16);
         end
         repeat (4) @(posedge clk);
         #1;
         cmp_ev(n_plr_b, eb_plr);
         cmp_ev(n_ifr_b, eb_ifr);
      end
      close_out();
   end
endmodule
`default_nettype wire
